// ==== hec_pkg.sv ====
// package of constants and types for the hopping encoder control block
package hec_pkg;
  localparam int          HEC_WORD_W     = 16;
  localparam int          HEC_NUM_WORDS  = 12;
  localparam int          HEC_ADDR_W     = 4;
  localparam logic [3:0]  HEC_A_KEY0     = 4'h0;
  localparam logic [3:0]  HEC_A_KEY3     = 4'h3;
  localparam logic [3:0]  HEC_A_COUNTER  = 4'h4;
  localparam logic [3:0]  HEC_A_RSVD5    = 4'h5;
  localparam logic [3:0]  HEC_A_SER_LO   = 4'h6;
  localparam logic [3:0]  HEC_A_SER_HI   = 4'h7;
  localparam logic [3:0]  HEC_A_LEARN_LO = 4'h8;
  localparam logic [3:0]  HEC_A_LEARN_HI = 4'h9;
  localparam logic [3:0]  HEC_A_RSVD10   = 4'ha;
  localparam logic [3:0]  HEC_A_OPTION   = 4'hb;
  localparam int          HEC_DISC_LSB   = 0;
  localparam int          HEC_DISC_MSB   = 9;
  localparam int          HEC_WRAP0_BIT  = 10;
  localparam int          HEC_WRAP1_BIT  = 11;
  localparam int          HEC_BATT_BIT   = 12;
  localparam int          HEC_RATE0_BIT  = 13;
  localparam int          HEC_RATE1_BIT  = 14;
  localparam int          HEC_RSVD_BIT   = 15;
  localparam int          HEC_SHUTOFF_BIT = 15;
  localparam int          HEC_SER_TX_W   = 28;
  localparam logic [3:0]  HEC_LEARN_COMBO = 4'hf;
  localparam logic [15:0] HEC_CNT_MAX    = 16'hffff;
  localparam int          HEC_CLK_MHZ    = 100;
  localparam int          HEC_DEBOUNCE_MS = 10;
  localparam int          HEC_DEBOUNCE_CYC = HEC_DEBOUNCE_MS * 1000 * HEC_CLK_MHZ;
  localparam int          HEC_SHUTOFF_S  = 25;
  localparam longint      HEC_SHUTOFF_CYC = longint'(HEC_SHUTOFF_S) * 1000000 * HEC_CLK_MHZ;
  localparam int          HEC_TE_400_US  = 400;
  localparam int          HEC_TE_200_US  = 200;
  localparam int          HEC_TE_100_US  = 100;
  localparam int          HEC_TE_400_CYC = HEC_TE_400_US * HEC_CLK_MHZ;
  localparam int          HEC_TE_200_CYC = HEC_TE_200_US * HEC_CLK_MHZ;
  localparam int          HEC_TE_100_CYC = HEC_TE_100_US * HEC_CLK_MHZ;
  localparam int          HEC_WORD_TE    = 66;
  typedef enum logic [2:0] {
    HEC_STANDBY, HEC_DEBOUNCE, HEC_ENCRYPT, HEC_SEND, HEC_TIMEOUT, HEC_PROGRAM
  } hec_state_t;
endpackage : hec_pkg

// ==== hec_param_mem.sv ====
// twelve-word parameter store with an addressed word load port and a counter and option writeback port
`timescale 1ns/1ps
`default_nettype none
module hec_param_mem
  import hec_pkg::*;
#(
  parameter int WORDS = HEC_NUM_WORDS,
  parameter int WIDTH = HEC_WORD_W
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  load_en,
  input  wire logic [HEC_ADDR_W-1:0] load_addr,
  input  wire logic [WIDTH-1:0]      load_data,
  input  wire logic                  wb_en,
  input  wire logic [WIDTH-1:0]      wb_counter,
  input  wire logic [WIDTH-1:0]      wb_option,
  output logic [WORDS*WIDTH-1:0]     words
);
  // one flip-flop word per entry; writeback touches only counter and option
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        words[i*WIDTH +: WIDTH] <= '0;
      end else if (load_en && load_addr == HEC_ADDR_W'(i)) begin
        words[i*WIDTH +: WIDTH] <= load_data;
      end else if (wb_en && HEC_ADDR_W'(i) == HEC_A_COUNTER) begin
        words[i*WIDTH +: WIDTH] <= wb_counter;
      end else if (wb_en && HEC_ADDR_W'(i) == HEC_A_OPTION) begin
        words[i*WIDTH +: WIDTH] <= wb_option;
      end
    end
  end
endmodule : hec_param_mem
`default_nettype wire

// ==== hec_control.sv ====
// top of the hopping encoder control: wake, debounce, code word building and sequencing
// How it works
// - button wake, 10 ms debounce, then sample
// - hop code encrypts counter, discriminator, buttons
// - new button aborts word, restarts fresh
// - released buttons finish word, then sleep
// - twelve sixteen-bit parameter words
// - key in words 0-3, low first
// - counter at word 4, bumps per transmission
// - serial in words 6-7, 28 bits sent
// - serial bit 31 enables auto shutoff
// - held button stops after 25 seconds
// - all buttons sends stored learn value
// - option word field layout fixed
// - counter wraps clear flag0 then flag1
// - cleared wrap flags never set again
// - button 2 is programming clock
// - transmit pin doubles as programming data
// - rate bits pick element and blanking
// - trip bit picks battery threshold
`timescale 1ns/1ps
`default_nettype none
module hec_control
  import hec_pkg::*;
#(
  parameter int     DEBOUNCE_CYC = HEC_DEBOUNCE_CYC,
  parameter longint SHUTOFF_CYC  = HEC_SHUTOFF_CYC,
  parameter int     TE_400_CYC   = HEC_TE_400_CYC,
  parameter int     TE_200_CYC   = HEC_TE_200_CYC,
  parameter int     TE_100_CYC   = HEC_TE_100_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        button_in0,
  input  wire logic        button_in1,
  input  wire logic        button_in2_prog_clock,
  input  wire logic        button_in3,
  input  wire logic        prog_mode,
  input  wire logic        prog_data_in,
  input  wire logic        battery_low,
  input  wire logic        cipher_done,
  input  wire logic [31:0] cipher_result,
  output logic             cipher_start,
  output logic [63:0]      cipher_key,
  output logic [31:0]      cipher_plain,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             indicator_drive_n,
  output logic             battery_trip_select,
  output logic [65:0]      code_word,
  output logic             word_strobe,
  output logic             word_blank,
  output logic             shutoff_active
);
  localparam int TE_W = 16;
  localparam int DB_W = 32;
  localparam int SO_W = 40;
  localparam int BIT_W = 7;
  localparam int PROG_BITS = HEC_ADDR_W + HEC_WORD_W;

  hec_state_t state;
  hec_state_t next_state;
  logic [HEC_NUM_WORDS*HEC_WORD_W-1:0] words;
  logic [3:0]      buttons;
  logic [3:0]      sampled;
  logic [DB_W-1:0] db_cnt;
  logic [SO_W-1:0] so_cnt;
  logic [TE_W-1:0] te_cnt;
  logic [BIT_W-1:0] bit_cnt;
  logic [1:0]      word_idx;
  logic [65:0]     shreg;
  logic            wb_en;
  logic [15:0]     wb_counter;
  logic [15:0]     wb_option;
  logic            clk2_d;
  logic [PROG_BITS-1:0] prog_sh;
  logic [4:0]      prog_cnt;
  logic            load_en;

  wire [15:0] counter_w = words[HEC_A_COUNTER*HEC_WORD_W +: HEC_WORD_W];
  wire [15:0] option_w  = words[HEC_A_OPTION*HEC_WORD_W +: HEC_WORD_W];
  wire [31:0] serial_w  = {words[HEC_A_SER_HI*HEC_WORD_W +: HEC_WORD_W],
                           words[HEC_A_SER_LO*HEC_WORD_W +: HEC_WORD_W]};
  wire [31:0] learn_w   = {words[HEC_A_LEARN_HI*HEC_WORD_W +: HEC_WORD_W],
                           words[HEC_A_LEARN_LO*HEC_WORD_W +: HEC_WORD_W]};
  wire [63:0] key_w     = words[HEC_A_KEY0*HEC_WORD_W +: 4*HEC_WORD_W];
  wire [9:0]  disc_w    = option_w[HEC_DISC_MSB:HEC_DISC_LSB];
  wire        rate_select0 = option_w[HEC_RATE0_BIT];
  wire        rate_select1 = option_w[HEC_RATE1_BIT];
  wire        wrap_flag0 = option_w[HEC_WRAP0_BIT];
  wire        wrap_flag1 = option_w[HEC_WRAP1_BIT];
  wire        shutoff_en = serial_w[HEC_SHUTOFF_BIT + HEC_WORD_W];

  // button 2 pin is the programming clock only in programming mode
  assign buttons = {button_in3, prog_mode ? 1'b0 : button_in2_prog_clock, button_in1, button_in0};
  wire any_btn   = |buttons;
  wire new_btn   = |(buttons & ~sampled);
  wire learn_sel = (sampled == HEC_LEARN_COMBO);
  wire cnt_wrap  = (counter_w == HEC_CNT_MAX);
  wire [15:0] cnt_inc = counter_w + 16'h0001;

  // first wrap clears flag0, second clears flag1; nothing here sets a flag
  wire clr0 = cnt_wrap && wrap_flag0;
  wire clr1 = cnt_wrap && !wrap_flag0 && wrap_flag1;
  wire [15:0] opt_next = option_w & ~(16'(clr0) << HEC_WRAP0_BIT) & ~(16'(clr1) << HEC_WRAP1_BIT);

  // rate select picks the basic element length and how many words go out blanked
  wire [TE_W-1:0] te_len = (!rate_select1 && !rate_select0) ? TE_W'(TE_400_CYC) :
                           (!rate_select1 &&  rate_select0) ? TE_W'(TE_200_CYC) :
                           TE_W'(TE_100_CYC);
  wire blank_now = (rate_select1 && rate_select0) ? (word_idx != 2'd0) :
                   (rate_select1 || rate_select0) ? word_idx[0] : 1'b0;
  wire te_tick  = (te_cnt == te_len - TE_W'(1));
  wire word_end = te_tick && (bit_cnt == BIT_W'(HEC_WORD_TE - 1));
  wire db_done  = (db_cnt == DB_W'(DEBOUNCE_CYC - 1));
  // sampling edge: buttons latched, counter bumped, cipher kicked
  wire sample_now = (state == HEC_DEBOUNCE) && db_done;
  // learn combo sends the stored value, so the cipher is left idle
  wire learn_now  = (buttons == HEC_LEARN_COMBO);
  // a word ending into standby or timeout must not announce another word
  wire word_again = word_end && (next_state == HEC_SEND);
  wire so_done  = shutoff_en && (so_cnt == SO_W'(SHUTOFF_CYC - 1));

  // fixed portion: 2 status bits, buttons, 28 serial bits; then 32-bit hop or learn value
  wire [31:0] hop_or_learn = learn_sel ? learn_w : cipher_result;
  wire [65:0] word_build = {1'b0, battery_low, sampled, serial_w[HEC_SER_TX_W-1:0],
                            hop_or_learn};

  always_comb begin
    next_state = state;
    case (state)
      HEC_STANDBY: begin
        if (prog_mode) next_state = HEC_PROGRAM;
        else if (any_btn) next_state = HEC_DEBOUNCE;
      end
      HEC_DEBOUNCE: begin
        if (!any_btn) next_state = HEC_STANDBY;
        else if (db_done) next_state = HEC_ENCRYPT;
      end
      HEC_ENCRYPT: begin
        if (new_btn) next_state = HEC_DEBOUNCE;
        else if (learn_sel || cipher_done) next_state = HEC_SEND;
      end
      HEC_SEND: begin
        if (new_btn) next_state = HEC_DEBOUNCE;
        else if (so_done) next_state = HEC_TIMEOUT;
        else if (word_end && !any_btn) next_state = HEC_STANDBY;
      end
      HEC_TIMEOUT: begin
        if (!any_btn) next_state = HEC_STANDBY;
      end
      HEC_PROGRAM: begin
        if (!prog_mode) next_state = HEC_STANDBY;
      end
      default: next_state = HEC_STANDBY;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state <= HEC_STANDBY;
    else state <= next_state;
  end

  // debounce counter restarts whenever debounce is (re)entered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) db_cnt <= '0;
    else if (state != HEC_DEBOUNCE) db_cnt <= '0;
    else db_cnt <= db_cnt + DB_W'(1);
  end

  // shutoff timer runs while a transmission is held; cleared in standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) so_cnt <= '0;
    else if (state == HEC_STANDBY || state == HEC_PROGRAM) so_cnt <= '0;
    else if (state == HEC_SEND && !so_done) so_cnt <= so_cnt + SO_W'(1);
  end

  // sample buttons at end of debounce; counter and flags written back one clock later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampled <= '0;
      wb_en <= 1'b0;
      wb_counter <= '0;
      wb_option <= '0;
    end else begin
      wb_en <= 1'b0;
      if (state == HEC_DEBOUNCE && db_done) begin
        sampled <= buttons;
        wb_en <= 1'b1;
        wb_counter <= cnt_inc;
        wb_option <= opt_next;
      end else if (state == HEC_STANDBY) begin
        sampled <= '0;
      end
    end
  end

  // plain block is frozen at the sampling edge with the incremented counter,
  // the same value written back, so it stands unchanged while the cipher works
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cipher_start <= 1'b0;
      cipher_key <= '0;
      cipher_plain <= '0;
    end else begin
      cipher_start <= sample_now && !learn_now;
      cipher_key <= key_w;
      if (sample_now) begin
        cipher_plain <= {buttons, 2'b00, disc_w, cnt_inc};
      end
    end
  end

  // element timing and word shifting; one bit per element keeps framing simple
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      te_cnt <= '0;
      bit_cnt <= '0;
      word_idx <= '0;
      shreg <= '0;
      code_word <= '0;
      word_strobe <= 1'b0;
      word_blank <= 1'b0;
    end else begin
      word_strobe <= 1'b0;
      if (state == HEC_ENCRYPT && next_state == HEC_SEND) begin
        te_cnt <= '0;
        bit_cnt <= '0;
        word_idx <= '0;
        shreg <= word_build;
        code_word <= word_build;
        word_strobe <= 1'b1;
        word_blank <= 1'b0;
      end else if (state == HEC_SEND) begin
        te_cnt <= te_tick ? '0 : te_cnt + TE_W'(1);
        if (word_end) begin
          bit_cnt <= '0;
          word_idx <= word_idx + 2'd1;
          shreg <= code_word;
          word_strobe <= word_again;
          word_blank <= (rate_select1 && rate_select0) ? (word_idx != 2'd3) :
                        (rate_select1 || rate_select0) ? !word_idx[0] : 1'b0;
        end else if (te_tick) begin
          bit_cnt <= bit_cnt + BIT_W'(1);
          shreg <= {1'b0, shreg[65:1]};
        end
      end
    end
  end

  // programming: address then data, shifted in on rising edges of button 2
  wire clk2_rise = prog_mode && button_in2_prog_clock && !clk2_d;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk2_d <= 1'b0;
      prog_sh <= '0;
      prog_cnt <= '0;
      load_en <= 1'b0;
    end else begin
      clk2_d <= button_in2_prog_clock;
      load_en <= 1'b0;
      if (!prog_mode) begin
        prog_cnt <= '0;
      end else if (clk2_rise) begin
        prog_sh <= {prog_data_in, prog_sh[PROG_BITS-1:1]};
        if (prog_cnt == 5'(PROG_BITS - 1)) begin
          prog_cnt <= '0;
          load_en <= 1'b1;
        end else begin
          prog_cnt <= prog_cnt + 5'd1;
        end
      end
    end
  end

  hec_param_mem u_mem (
    .clk        (clk),
    .rst        (rst),
    .load_en    (load_en),
    .load_addr  (prog_sh[HEC_ADDR_W-1:0]),
    .load_data  (prog_sh[PROG_BITS-1:HEC_ADDR_W]),
    .wb_en      (wb_en),
    .wb_counter (wb_counter),
    .wb_option  (wb_option),
    .words      (words)
  );

  // pin drive: in programming mode the transmit pin turns into a data input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_out <= 1'b0;
      tx_oe <= 1'b1;
      indicator_drive_n <= 1'b1;
      battery_trip_select <= 1'b0;
      shutoff_active <= 1'b0;
    end else begin
      tx_out <= (state == HEC_SEND) && !blank_now && shreg[0];
      tx_oe <= (state != HEC_PROGRAM);
      indicator_drive_n <= !(state == HEC_SEND);
      battery_trip_select <= option_w[HEC_BATT_BIT];
      shutoff_active <= (state == HEC_TIMEOUT);
    end
  end
endmodule : hec_control
`default_nettype wire

// ==== hec_control_properties.sv ====
// port assertions for the hopping encoder control
`timescale 1ns/1ps
`default_nettype none
module hec_control_properties
  import hec_pkg::*;
#(parameter int DEBOUNCE_CYC = HEC_DEBOUNCE_CYC) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        button_in0,
  input wire logic        button_in1,
  input wire logic        button_in2_prog_clock,
  input wire logic        button_in3,
  input wire logic        prog_mode,
  input wire logic        cipher_start,
  input wire logic [31:0] cipher_plain,
  input wire logic        tx_out,
  input wire logic        tx_oe,
  input wire logic        indicator_drive_n,
  input wire logic        word_strobe,
  input wire logic        word_blank,
  input wire logic        shutoff_active
);
  logic [3:0]  btn;
  logic [31:0] held;
  assign btn = {button_in3, button_in2_prog_clock, button_in1, button_in0};
  // saturating count of cycles with a button down, so a stuck key cannot wrap it
  always_ff @(posedge clk or posedge rst)
    if (rst) held <= '0;
    else if (btn == 4'h0 || prog_mode) held <= '0;
    else if (held != '1) held <= held + 32'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_prog_no_drive: assert property (prog_mode [*3] |-> !tx_oe)
    else $error("tx pin driven while programming");
  a_run_drives_pin: assert property (!prog_mode [*3] |-> tx_oe)
    else $error("tx pin released outside programming");
  a_debounce_wait: assert property (cipher_start |-> held >= 32'(DEBOUNCE_CYC))
    else $error("encryption began before debounce ended");
  a_plain_fields: assert property (cipher_start |-> cipher_plain[31:26] == {btn, 2'b00}
      && btn != HEC_LEARN_COMBO) else $error("bad plain block or learn combo encrypted");
  a_start_pulse: assert property (cipher_start |=> !cipher_start)
    else $error("encryption start longer than one cycle");
  a_idle_quiet: assert property ((indicator_drive_n && !prog_mode) [*2] |-> !tx_out)
    else $error("tx active while idle");
  a_blank_silent: assert property (word_blank [*2] |-> !tx_out)
    else $error("tx active in blanked word");
  a_shutoff_silent: assert property (shutoff_active [*2] |-> !tx_out && !word_strobe)
    else $error("transmitting after shutoff");
  a_word_spacing: assert property (word_strobe |=> !word_strobe [*8])
    else $error("word starts too close");
  c_word_sent: cover property (word_strobe && !word_blank);
  c_word_blanked: cover property (word_strobe && word_blank);
  c_shutoff: cover property ($rose(shutoff_active));
endmodule : hec_control_properties
bind hec_control hec_control_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (
  .clk, .rst, .button_in0, .button_in1, .button_in2_prog_clock, .button_in3, .prog_mode,
  .cipher_start, .cipher_plain, .tx_out, .tx_oe, .indicator_drive_n, .word_strobe,
  .word_blank, .shutoff_active);
`default_nettype wire

// ==== hec_far_side.sv ====
// stand-in for the external cipher engine beside the encoder
`timescale 1ns/1ps
`default_nettype none
module hec_far_side #(parameter int LAT = 3) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        slow,
  input wire logic        cipher_start,
  input wire logic [63:0] cipher_key,
  input wire logic [31:0] cipher_plain,
  output logic            cipher_done,
  output logic [31:0]     cipher_result
);
  int cnt;
  // xor, not a real cipher: the bench only needs a result it can predict
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      cipher_done <= 1'b0;
      cipher_result <= 32'h0;
    end else begin
      cipher_done <= 1'b0;
      cipher_result <= ~cipher_result;
      if (cipher_start) begin
        cnt <= slow ? LAT * 8 : LAT;
      end else if (cnt == 1) begin
        cnt <= 0;
        cipher_done <= 1'b1;
        cipher_result <= cipher_plain ^ cipher_key[31:0];
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : hec_far_side
`default_nettype wire

// ==== hec_control_tb.sv ====
// self-checking bench for the hopping encoder control
`timescale 1ns/1ps
`default_nettype none
module hec_control_tb
  import hec_pkg::*;
;
  localparam int DEB = 10;
  localparam int SHUT = 300;
  localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
  localparam logic [15:0] IMG [12] = '{16'hcdef, 16'h89ab, 16'h4567, 16'h0123, 16'h1000,
    16'h0000, 16'h5678, 16'h1234, 16'hbeef, 16'hcafe, 16'h0000, 16'h1e78};
  logic        clk, rst, prog_mode, prog_data_in, battery_low, slow, cipher_done;
  logic        cipher_start, tx_out, tx_oe, indicator_drive_n, battery_trip_select;
  logic        word_strobe, word_blank, shutoff_active;
  logic [3:0]  btn;
  logic [31:0] cipher_result, cipher_plain;
  logic [63:0] cipher_key;
  logic [65:0] code_word;
  int          n_errors = 0, num_checks = 0, n_start = 0, n_word = 0, cyc = 0;
  hec_control #(.DEBOUNCE_CYC(DEB), .SHUTOFF_CYC(SHUT), .TE_400_CYC(4), .TE_200_CYC(3),
    .TE_100_CYC(2)) dut (.clk, .rst, .button_in0(btn[0]), .button_in1(btn[1]),
    .button_in2_prog_clock(btn[2]), .button_in3(btn[3]), .prog_mode, .prog_data_in,
    .battery_low, .cipher_done, .cipher_result, .cipher_start, .cipher_key, .cipher_plain,
    .tx_out, .tx_oe, .indicator_drive_n, .battery_trip_select, .code_word, .word_strobe,
    .word_blank, .shutoff_active);
  hec_far_side #(.LAT(3)) far (.clk, .rst, .slow, .cipher_start, .cipher_key, .cipher_plain,
    .cipher_done, .cipher_result);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cipher_start === 1'b1) n_start++;
    if (word_strobe === 1'b1) n_word++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  task automatic wait_on(ref logic s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < 1000);
    chk(n < 1000, 1'b1);
  endtask : wait_on
  task automatic press(input logic [3:0] v);
    @(posedge clk);
    btn <= v;
  endtask : press
  // address nibble then data, low bit first; data held across each clock rise
  task automatic prog_word(input logic [3:0] a, input logic [15:0] d);
    logic [19:0] f;
    f = {d, a};
    @(posedge clk);
    prog_mode <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      prog_data_in <= f[i];
      btn[2] <= 1'b0;
      cycles(2);
      btn[2] <= 1'b1;
      cycles(2);
    end
    btn[2] <= 1'b0;
    cycles(3);
    chk(tx_oe, 1'b0);
    prog_mode <= 1'b0;
  endtask : prog_word
  task automatic t_press();
    int n, k;
    logic [65:0] w;
    w = {2'b00, 4'h1, 28'h2345678, {4'h1, 2'b00, 10'h278, 16'h1001} ^ KEY[31:0]};
    press(4'h1);
    wait_on(cipher_start, 1'b1, n);
    chk(n >= DEB && n <= DEB + 8, 1'b1);
    chk(cipher_key, KEY);
    chk(cipher_plain, {4'h1, 2'b00, 10'h278, 16'h1001});
    wait_on(word_strobe, 1'b1, n);
    chk(code_word, w);
    chk(battery_trip_select, 1'b1);
    for (int i = 0; i < 66; i++) begin
      cycles(i == 0 ? 2 : 4);
      if (i == 10) begin
        btn <= 4'h0;
        k = n_word;
      end
      chk(tx_out, w[i]);
    end
    wait_on(indicator_drive_n, 1'b1, n);
    chk(n_word, k);
  endtask : t_press
  task automatic t_abort();
    int n;
    press(4'h1);
    wait_on(word_strobe, 1'b1, n);
    chk(cipher_plain[15:0], 16'h1002);
    cycles(20);
    btn <= 4'h3;
    wait_on(cipher_start, 1'b1, n);
    chk(n >= DEB && n <= DEB + 8, 1'b1);
    chk(cipher_plain, {4'h3, 2'b00, 10'h278, 16'h1003});
    wait_on(word_strobe, 1'b1, n);
    chk(code_word[63:60], 4'h3);
    btn <= 4'h0;
    wait_on(indicator_drive_n, 1'b1, n);
  endtask : t_abort
  task automatic t_rates();
    int n, te;
    for (int r = 0; r < 4; r++) begin
      te = (r == 0) ? 4 : (r == 1) ? 3 : 2;
      prog_word(HEC_A_OPTION, {1'b0, 2'(r), 13'h1e78});
      press(4'h2);
      wait_on(word_strobe, 1'b1, n);
      for (int k = 0; k < 4; k++) begin
        if (k > 0) begin
          wait_on(word_strobe, 1'b1, n);
          chk(n, 66 * te);
        end
        chk(word_blank, r == 0 ? 1'b0 : r == 3 ? k != 0 : k % 2 == 1);
      end
      btn <= 4'h0;
      wait_on(indicator_drive_n, 1'b1, n);
      chk(shutoff_active, 1'b0);
    end
  endtask : t_rates
  task automatic t_learn();
    int n, k;
    k = n_start;
    press(4'hf);
    wait_on(word_strobe, 1'b1, n);
    chk(code_word[63:0], {4'hf, 28'h2345678, 32'hcafebeef});
    chk(n_start, k);
    btn <= 4'h0;
    wait_on(indicator_drive_n, 1'b1, n);
  endtask : t_learn
  task automatic t_shutoff();
    int n, k;
    prog_word(HEC_A_COUNTER, 16'hffff);
    prog_word(HEC_A_SER_HI, 16'h9234);
    battery_low <= 1'b1;
    press(4'h1);
    wait_on(cipher_start, 1'b1, n);
    chk(cipher_plain[15:0], 16'h0000);
    wait_on(word_strobe, 1'b1, n);
    chk(code_word[65:60], 6'h11);
    wait_on(shutoff_active, 1'b1, n);
    chk(n >= SHUT - DEB - 8 && n <= SHUT + 8, 1'b1);
    k = n_word;
    cycles(300);
    chk(n_word, k);
    btn <= 4'h0;
    wait_on(shutoff_active, 1'b0, n);
    battery_low <= 1'b0;
  endtask : t_shutoff
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    {clk, rst, btn, prog_mode, prog_data_in, battery_low, slow} = 10'h100;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cycles(2);
    for (int a = 0; a < 12; a++) prog_word(4'(a), IMG[a]);
    cycles(4);
    chk(tx_oe, 1'b1);
    t_press();
    slow <= 1'b1;
    t_abort();
    slow <= 1'b0;
    t_rates();
    t_learn();
    t_shutoff();
    end_of_test();
  end
endmodule : hec_control_tb
`default_nettype wire
